// ==== rtl/nvt_ctrl.sv ====
`timescale 1ns/1ps
// Contract
// - Power-up restore ends within 20 ms, or 40 ms on the low-voltage variant.
// - Power-loss or pin save is skipped when nothing was written since last operation.
// - SRAM writes stay enabled for a 25 ns grace when a save starts; here only pin and power-loss saves get one 50 ns cycle.
// - Reads and writes ignored during save, recall, and low supply.
// - Save or recall locks out serial I/O; save 8 ms, recall 600 us.
// - Software commands are acted on within 500 us.
// - Sleep command reaches low-power state within 8 ms.
// - Wake from sleep gives access within 20 ms, or 40 ms low-voltage.
// - After STOP the device enters standby within 100 us.
// - Device active within 5 us after the save/busy pin goes high.
module nvt_ctrl #(
    parameter bit LOW_VOLT = 1'b0,
    parameter int unsigned RESTORE_CYCLES = LOW_VOLT ? nvt_pkg::RESTORE_LV_CYC
                                                     : nvt_pkg::RESTORE_CYC,
    parameter int unsigned SAVE_CYCLES    = nvt_pkg::SAVE_CYC,
    parameter int unsigned SLEEP_CYCLES   = nvt_pkg::SLEEP_CYC,
    parameter int unsigned WAKE_CYCLES    = LOW_VOLT ? nvt_pkg::WAKE_LV_CYC
                                                     : nvt_pkg::WAKE_CYC
) (
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       LOW_SUPPLY_TRIP,
    input  wire logic       HW_SAVE_BUSY_PIN_I,
    output logic            HW_SAVE_BUSY_PIN_O,
    output logic            HW_SAVE_BUSY_PIN_OE,
    input  wire logic       AUTO_SAVE_ON_POWER_LOSS,
    input  wire logic       CMD_VALID,
    input  wire nvt_pkg::nvt_cmd_t CMD,
    input  wire logic       BUS_STOP,
    input  wire logic       WAKE_REQ,
    input  wire logic       SRAM_WRITE,
    output logic            ACCESS_EN,
    output logic            WRITE_EN,
    output logic            IO_LOCK,
    output logic            STANDBY,
    output logic            SLEEP,
    output logic            NV_SAVE_GO,
    output logic            NV_RECALL_GO
);
    typedef struct packed {
        nvt_pkg::nvt_state_t   state;
        nvt_pkg::nvt_cmd_t     cmd;
        logic                  dirty;
        logic                  hw_save;
        logic                  stby_arm;
        logic                  standby;
        logic                  save_go;
        logic                  recall_go;
        logic [1:0]            lowv_s;
        logic [1:0]            hsb_s;
        logic [nvt_pkg::CNT_W-1:0] stby_cnt;
    } nvt_st_t;

    nvt_st_t st_reg;
    nvt_st_t st_next;
    nvt_timer_if tif ();

    nvt_timer u_timer (
        .clk  (CLK),
        .nrst (NRST),
        .t    (tif)
    );

    logic lowv;
    logic hsb_low;
    logic busy;
    assign lowv    = st_reg.lowv_s[1];
    assign hsb_low = !st_reg.hsb_s[1];

    always_comb
    begin
        st_next           = st_reg;
        st_next.lowv_s    = {st_reg.lowv_s[0], LOW_SUPPLY_TRIP};
        st_next.hsb_s     = {st_reg.hsb_s[0], HW_SAVE_BUSY_PIN_I};
        st_next.save_go   = 1'b0;
        st_next.recall_go = 1'b0;
        tif.load          = 1'b0;
        tif.value         = '0;
        if (SRAM_WRITE && WRITE_EN)
        begin
            st_next.dirty = 1'b1;
        end
        unique case (st_reg.state)
            nvt_pkg::NVT_RESTORE:
            begin
                if (tif.done)
                begin
                    st_next.state = nvt_pkg::NVT_ACTIVE;
                end
            end
            nvt_pkg::NVT_ACTIVE, nvt_pkg::NVT_IDLE:
            begin
                if (AUTO_SAVE_ON_POWER_LOSS && lowv || hsb_low)
                begin
                    st_next.hw_save = hsb_low;
                    if (st_reg.dirty)
                    begin
                        st_next.state = nvt_pkg::NVT_GRACE;
                        tif.load      = 1'b1;
                        tif.value     = nvt_pkg::CNT_W'(nvt_pkg::GRACE_CYC);
                    end
                    else
                    begin
                        st_next.state = hsb_low ? nvt_pkg::NVT_HW_HOLD
                                                : nvt_pkg::NVT_LOWV;
                    end
                end
                else if (CMD_VALID)
                begin
                    st_next.cmd   = CMD;
                    st_next.state = nvt_pkg::NVT_SEQ;
                    tif.load      = 1'b1;
                    tif.value     = nvt_pkg::CNT_W'(nvt_pkg::SEQ_CYC);
                end
            end
            nvt_pkg::NVT_SEQ:
            begin
                // Commands start at the end of the processing window
                if (tif.done)
                begin
                    tif.load = 1'b1;
                    unique case (st_reg.cmd)
                        nvt_pkg::NVT_CMD_SAVE:
                        begin
                            st_next.state   = nvt_pkg::NVT_SAVE;
                            st_next.save_go = 1'b1;
                            st_next.hw_save = 1'b0;
                            tif.value = nvt_pkg::CNT_W'(SAVE_CYCLES);
                        end
                        nvt_pkg::NVT_CMD_RECALL:
                        begin
                            st_next.state     = nvt_pkg::NVT_RECALL;
                            st_next.recall_go = 1'b1;
                            tif.value = nvt_pkg::CNT_W'(nvt_pkg::RECALL_CYC);
                        end
                        default:
                        begin
                            st_next.state = nvt_pkg::NVT_SLEEPING;
                            tif.value = nvt_pkg::CNT_W'(SLEEP_CYCLES);
                        end
                    endcase
                end
            end
            nvt_pkg::NVT_GRACE:
            begin
                if (tif.done)
                begin
                    st_next.state   = nvt_pkg::NVT_SAVE;
                    st_next.save_go = 1'b1;
                    tif.load        = 1'b1;
                    tif.value       = nvt_pkg::CNT_W'(SAVE_CYCLES);
                end
            end
            nvt_pkg::NVT_SAVE:
            begin
                if (tif.done)
                begin
                    // A write during the grace window still counts as saved
                    st_next.dirty = 1'b0;
                    // Own busy drive lingers in the synchroniser, so settle before access
                    st_next.state = st_reg.hw_save ? nvt_pkg::NVT_HW_HOLD
                                  : (lowv ? nvt_pkg::NVT_LOWV : nvt_pkg::NVT_REARM);
                    tif.load      = !st_reg.hw_save;
                    tif.value     = nvt_pkg::CNT_W'(nvt_pkg::ACTIVE_CYC);
                end
            end
            nvt_pkg::NVT_RECALL:
            begin
                if (tif.done)
                begin
                    st_next.dirty = 1'b0;
                    st_next.state = nvt_pkg::NVT_ACTIVE;
                end
            end
            nvt_pkg::NVT_SLEEPING:
            begin
                if (tif.done)
                begin
                    st_next.state = nvt_pkg::NVT_ASLEEP;
                end
            end
            nvt_pkg::NVT_ASLEEP:
            begin
                if (WAKE_REQ)
                begin
                    st_next.state = nvt_pkg::NVT_WAKING;
                    tif.load      = 1'b1;
                    tif.value     = nvt_pkg::CNT_W'(WAKE_CYCLES);
                end
            end
            nvt_pkg::NVT_WAKING:
            begin
                if (tif.done)
                begin
                    st_next.state = nvt_pkg::NVT_ACTIVE;
                end
            end
            nvt_pkg::NVT_HW_HOLD:
            begin
                // Pin released: short settle before accesses resume
                if (!hsb_low)
                begin
                    st_next.hw_save = 1'b0;
                    st_next.state   = nvt_pkg::NVT_REARM;
                    tif.load        = 1'b1;
                    tif.value       = nvt_pkg::CNT_W'(nvt_pkg::ACTIVE_CYC);
                end
            end
            nvt_pkg::NVT_REARM:
            begin
                if (tif.done)
                begin
                    st_next.state = nvt_pkg::NVT_ACTIVE;
                end
            end
            nvt_pkg::NVT_LOWV:
            begin
                // Supply back above trip: restore as on power-up
                if (!lowv)
                begin
                    st_next.state = nvt_pkg::NVT_RESTORE;
                    tif.load      = 1'b1;
                    tif.value     = nvt_pkg::CNT_W'(RESTORE_CYCLES);
                end
            end
            default:
            begin
                st_next.state = nvt_pkg::NVT_LOWV;
            end
        endcase
        // Standby entry timer after a STOP
        if (st_next.state != nvt_pkg::NVT_ACTIVE)
        begin
            st_next.stby_arm = 1'b0;
            st_next.standby  = 1'b0;
        end
        else if (BUS_STOP)
        begin
            st_next.stby_arm = 1'b1;
            st_next.stby_cnt = nvt_pkg::CNT_W'(nvt_pkg::STANDBY_CYC - 1);
        end
        else if (CMD_VALID)
        begin
            st_next.stby_arm = 1'b0;
            st_next.standby  = 1'b0;
        end
        else if (st_reg.stby_arm)
        begin
            if (st_reg.stby_cnt == '0)
            begin
                st_next.stby_arm = 1'b0;
                st_next.standby  = 1'b1;
            end
            else
            begin
                st_next.stby_cnt = st_reg.stby_cnt - 1'b1;
            end
        end
        if (lowv && st_reg.state != nvt_pkg::NVT_GRACE && st_reg.state != nvt_pkg::NVT_SAVE
            && st_reg.state != nvt_pkg::NVT_LOWV && !(AUTO_SAVE_ON_POWER_LOSS && st_reg.dirty
            && (st_reg.state == nvt_pkg::NVT_ACTIVE || st_reg.state == nvt_pkg::NVT_IDLE)))
        begin
            st_next.state = nvt_pkg::NVT_LOWV;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            st_reg       <= '0;
            st_reg.state <= nvt_pkg::NVT_LOWV;
            st_reg.lowv_s <= 2'h3;
            st_reg.hsb_s <= 2'h3;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Accesses are dropped whenever an operation or low supply is in progress
    assign busy     = !(st_reg.state == nvt_pkg::NVT_ACTIVE || st_reg.state == nvt_pkg::NVT_SEQ);
    assign ACCESS_EN = !busy && !lowv;
    assign WRITE_EN  = ACCESS_EN || st_reg.state == nvt_pkg::NVT_GRACE;
    assign IO_LOCK   = busy;
    assign STANDBY   = st_reg.standby;
    assign SLEEP     = st_reg.state == nvt_pkg::NVT_ASLEEP;
    assign NV_SAVE_GO   = st_reg.save_go;
    assign NV_RECALL_GO = st_reg.recall_go;
    // Drive the pin low as a busy flag while any save runs
    assign HW_SAVE_BUSY_PIN_O  = 1'b0;
    assign HW_SAVE_BUSY_PIN_OE = st_reg.state == nvt_pkg::NVT_SAVE
                              || st_reg.state == nvt_pkg::NVT_GRACE;

    a_save_lock: assert property (@(posedge CLK) disable iff (!NRST)
        st_reg.state == nvt_pkg::NVT_SAVE |-> IO_LOCK && !ACCESS_EN)
        else $error("io not locked during save");
    a_recall_lock: assert property (@(posedge CLK) disable iff (!NRST)
        st_reg.state == nvt_pkg::NVT_RECALL |-> !ACCESS_EN)
        else $error("access during recall");
    a_lowv_block: assert property (@(posedge CLK) disable iff (!NRST)
        lowv |-> !ACCESS_EN)
        else $error("access at low supply");
    a_grace_write: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(st_reg.state == nvt_pkg::NVT_GRACE) |-> WRITE_EN ##1 !WRITE_EN)
        else $error("write grace missing");
    a_clean_skip: assert property (@(posedge CLK) disable iff (!NRST)
        NV_SAVE_GO && $past(st_reg.state) == nvt_pkg::NVT_GRACE |-> $past(st_reg.dirty, 2))
        else $error("save without dirty data");
    logic [nvt_pkg::CNT_W-1:0] seq_age_reg;
    logic [nvt_pkg::CNT_W-1:0] stop_age_reg;
    always_ff @(posedge CLK)
    begin
        seq_age_reg  <= (!NRST || st_reg.state != nvt_pkg::NVT_SEQ) ? '0 : seq_age_reg + 1'b1;
        stop_age_reg <= (!NRST || BUS_STOP || !st_reg.stby_arm) ? '0 : stop_age_reg + 1'b1;
    end
    sequence s_stop;
        st_reg.state == nvt_pkg::NVT_ACTIVE && BUS_STOP && !CMD_VALID && !lowv && !hsb_low;
    endsequence
    a_stop_stby: assert property (@(posedge CLK) disable iff (!NRST)
        s_stop |=> st_reg.stby_arm)
        else $error("standby count not started");
    a_stby_bound: assert property (@(posedge CLK) disable iff (!NRST)
        st_reg.stby_arm |-> stop_age_reg < nvt_pkg::CNT_W'(nvt_pkg::STANDBY_CYC))
        else $error("standby not entered in time");
    a_seq_bound: assert property (@(posedge CLK) disable iff (!NRST)
        st_reg.state == nvt_pkg::NVT_SEQ |-> seq_age_reg < nvt_pkg::CNT_W'(nvt_pkg::SEQ_CYC))
        else $error("command not acted on in time");
    a_rearm_bound: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(st_reg.state == nvt_pkg::NVT_REARM) |-> ##[1:101] ACCESS_EN || lowv)
        else $error("not active after pin release");
endmodule : nvt_ctrl

// ==== rtl/nvt_pkg.sv ====
package nvt_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 50;

    // Durations as printed, in their own units
    localparam int unsigned RESTORE_MS      = 20;
    localparam int unsigned RESTORE_LV_MS   = 40;
    localparam int unsigned SAVE_MS         = 8;
    localparam int unsigned RECALL_US       = 600;
    localparam int unsigned SEQ_US          = 500;
    localparam int unsigned SLEEP_MS        = 8;
    localparam int unsigned WAKE_MS         = 20;
    localparam int unsigned WAKE_LV_MS      = 40;
    localparam int unsigned STANDBY_US      = 100;
    localparam int unsigned GRACE_NS        = 25;
    localparam int unsigned ACTIVE_US       = 5;

    // Longest times round down, never below one cycle
    function automatic int unsigned max_cyc(input longint unsigned ns);
        longint unsigned c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction : max_cyc

    localparam int unsigned RESTORE_CYC     = max_cyc(64'(RESTORE_MS) * 1_000_000);
    localparam int unsigned RESTORE_LV_CYC  = max_cyc(64'(RESTORE_LV_MS) * 1_000_000);
    localparam int unsigned SAVE_CYC        = max_cyc(64'(SAVE_MS) * 1_000_000);
    localparam int unsigned RECALL_CYC      = max_cyc(64'(RECALL_US) * 1_000);
    localparam int unsigned SEQ_CYC         = max_cyc(64'(SEQ_US) * 1_000);
    localparam int unsigned SLEEP_CYC       = max_cyc(64'(SLEEP_MS) * 1_000_000);
    localparam int unsigned WAKE_CYC        = max_cyc(64'(WAKE_MS) * 1_000_000);
    localparam int unsigned WAKE_LV_CYC     = max_cyc(64'(WAKE_LV_MS) * 1_000_000);
    localparam int unsigned STANDBY_CYC     = max_cyc(64'(STANDBY_US) * 1_000);
    localparam int unsigned GRACE_CYC       = max_cyc(64'(GRACE_NS));
    localparam int unsigned ACTIVE_CYC      = max_cyc(64'(ACTIVE_US) * 1_000);

    localparam int unsigned CNT_W           = 20;

    typedef enum logic [1:0] {
        NVT_CMD_SAVE,
        NVT_CMD_RECALL,
        NVT_CMD_SLEEP
    } nvt_cmd_t;

    typedef enum logic [3:0] {
        NVT_RESTORE,
        NVT_ACTIVE,
        NVT_IDLE,
        NVT_SEQ,
        NVT_GRACE,
        NVT_SAVE,
        NVT_RECALL,
        NVT_SLEEPING,
        NVT_ASLEEP,
        NVT_WAKING,
        NVT_HW_HOLD,
        NVT_REARM,
        NVT_LOWV
    } nvt_state_t;

endpackage : nvt_pkg

// ==== rtl/nvt_timer_if.sv ====
`timescale 1ns/1ps
interface nvt_timer_if;
    logic                       load;
    logic [nvt_pkg::CNT_W-1:0]  value;
    logic                       done;

    modport ctrl (output load, output value, input done);
    modport tmr  (input load, input value, output done);
endinterface : nvt_timer_if

// ==== rtl/nvt_timer.sv ====
`timescale 1ns/1ps
module nvt_timer (
    input  wire logic   clk,
    input  wire logic   nrst,
    nvt_timer_if.tmr    t
);
    typedef struct packed {
        logic [nvt_pkg::CNT_W-1:0] cnt;
        logic                      run;
    } nvt_tmr_st_t;

    nvt_tmr_st_t st_reg;
    nvt_tmr_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (t.load)
        begin
            st_next.cnt = t.value;
            st_next.run = 1'b1;
        end
        else if (st_reg.run && st_reg.cnt != '0)
        begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
        else
        begin
            st_next.run = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Done marks the last cycle of a load, so a state lasts the loaded count
    // Load is not read here: the controller raises load from done
    assign t.done = st_reg.run && (st_reg.cnt == nvt_pkg::CNT_W'(1));
endmodule : nvt_timer

// ==== verif/nvt_master_model.sv ====
`timescale 1ns/1ps
module nvt_master_model (
    input  wire logic          clk,
    input  wire logic          access_en,
    output logic               cmd_valid,
    output nvt_pkg::nvt_cmd_t  cmd,
    output logic               bus_stop,
    output logic               sram_write
);
    initial
    begin
        cmd_valid  = 1'b0;
        cmd        = nvt_pkg::NVT_CMD_SLEEP;
        bus_stop   = 1'b0;
        sram_write = 1'b0;
    end

    // Kind 0 command, 1 memory write, 2 STOP; one cycle each
    task automatic send(input int kind, input nvt_pkg::nvt_cmd_t c, output bit ok);
        // Never talks to a busy device, its answers would be dropped
        ok = (access_en === 1'b1);
        if (ok)
        begin
            @(posedge clk);
            #5;
            cmd        = c;
            cmd_valid  = (kind == 0);
            sram_write = (kind == 1);
            bus_stop   = (kind == 2);
            @(posedge clk);
            #5;
            cmd_valid  = 1'b0;
            sram_write = 1'b0;
            bus_stop   = 1'b0;
            // Released command lines do not keep the last value
            cmd        = nvt_pkg::nvt_cmd_t'(~c);
        end
    endtask : send
endmodule : nvt_master_model

// ==== verif/nvt_ctrl_tb.sv ====
`timescale 1ns/1ps
module nvt_ctrl_tb;
    localparam int RC  = 50;
    localparam int SC  = 50;
    localparam int SLC = 50;
    localparam int WC  = 50;
    localparam int B_ACC = 0;
    localparam int B_SGO = 1;
    localparam int B_RGO = 2;
    localparam int B_SLP = 3;
    localparam int B_STB = 4;

    logic              clk;
    logic              nrst;
    logic              low_trip;
    logic              pin_low;
    logic              auto_save;
    logic              wake_req;
    logic              pin_o;
    logic              pin_oe;
    logic              pin_lvl;
    logic              cmd_valid;
    nvt_pkg::nvt_cmd_t cmd;
    logic              bus_stop;
    logic              sram_write;
    logic              access_en;
    logic              write_en;
    logic              io_lock;
    logic              standby;
    logic              sleep;
    logic              save_go;
    logic              recall_go;
    logic [4:0]        obs;
    int                mismatches;
    int                n_compared;

    // Open-drain pin with external pull-up
    assign pin_lvl = ~(pin_low | (pin_oe & ~pin_o));
    assign obs     = {standby, sleep, recall_go, save_go, access_en};

    always #25 clk = ~clk;

    nvt_ctrl #(
        .RESTORE_CYCLES (RC),
        .SAVE_CYCLES    (SC),
        .SLEEP_CYCLES   (SLC),
        .WAKE_CYCLES    (WC)
    ) dut_u (
        .CLK                     (clk),
        .NRST                    (nrst),
        .LOW_SUPPLY_TRIP         (low_trip),
        .HW_SAVE_BUSY_PIN_I      (pin_lvl),
        .HW_SAVE_BUSY_PIN_O      (pin_o),
        .HW_SAVE_BUSY_PIN_OE     (pin_oe),
        .AUTO_SAVE_ON_POWER_LOSS (auto_save),
        .CMD_VALID               (cmd_valid),
        .CMD                     (cmd),
        .BUS_STOP                (bus_stop),
        .WAKE_REQ                (wake_req),
        .SRAM_WRITE              (sram_write),
        .ACCESS_EN               (access_en),
        .WRITE_EN                (write_en),
        .IO_LOCK                 (io_lock),
        .STANDBY                 (standby),
        .SLEEP                   (sleep),
        .NV_SAVE_GO              (save_go),
        .NV_RECALL_GO            (recall_go)
    );

    nvt_master_model master_u (
        .clk        (clk),
        .access_en  (access_en),
        .cmd_valid  (cmd_valid),
        .cmd        (cmd),
        .bus_stop   (bus_stop),
        .sram_write (sram_write)
    );

    task automatic complete_run;
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #5;
    endtask : tick

    task automatic check(input bit ok, input string msg);
        n_compared++;
        if (!ok)
        begin
            mismatches++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check

    // Bounded wait for an observed output; running out ends the run
    task automatic wait_bit(input int b, input logic v, input int lim, output int n);
        n = 0;
        while (obs[b] !== v)
        begin
            if (n >= lim)
            begin
                mismatches++;
                $display("ERROR %0t wait on output %0d timed out", $time, b);
                complete_run();
            end
            tick(1);
            n++;
        end
    endtask : wait_bit

    task automatic send_ok(input int kind, input nvt_pkg::nvt_cmd_t c);
        bit ok;
        master_u.send(kind, c, ok);
        check(ok, "master found device not ready");
    endtask : send_ok

    task automatic t_restore;
        int n;
        check(access_en === 1'b0 && io_lock === 1'b1, "access open during restore");
        wait_bit(B_ACC, 1'b1, RC + 20, n);
        check(n >= RC - 5, "restore ended too early");
    endtask : t_restore

    task automatic t_sw_op(input nvt_pkg::nvt_cmd_t c, input int bgo, input int dur);
        int n;
        send_ok(0, c);
        wait_bit(bgo, 1'b1, nvt_pkg::SEQ_CYC + 5, n);
        check(io_lock === 1'b1 && access_en === 1'b0, "io not locked in nv op");
        wait_bit(B_ACC, 1'b1, dur + 10, n);
        check(n >= dur - 5, "nv op ended too early");
    endtask : t_sw_op

    task automatic t_hw_clean;
        int n;
        bit bad;
        bad     = 1'b0;
        pin_low = 1'b1;
        repeat (20)
        begin
            tick(1);
            if (save_go === 1'b1 || pin_oe === 1'b1)
                bad = 1'b1;
        end
        check(!bad, "save ran with nothing written");
        pin_low = 1'b0;
        wait_bit(B_ACC, 1'b1, nvt_pkg::ACTIVE_CYC + 10, n);
    endtask : t_hw_clean

    task automatic t_hw_dirty;
        int n;
        int grace;
        grace = 0;
        send_ok(1, nvt_pkg::NVT_CMD_SAVE);
        pin_low = 1'b1;
        for (n = 0; n < 10 && save_go !== 1'b1; n++)
        begin
            tick(1);
            if (write_en === 1'b1 && access_en === 1'b0)
                grace++;
        end
        check(save_go === 1'b1, "pin save not started");
        check(grace >= 1 && grace <= 2, "write grace wrong length");
        check(pin_oe === 1'b1 && pin_o === 1'b0 && access_en === 1'b0, "access open in pin save");
        pin_low = 1'b0;
        wait_bit(B_ACC, 1'b1, SC + nvt_pkg::ACTIVE_CYC + 15, n);
        check(n >= SC - 5, "pin save too short");
    endtask : t_hw_dirty

    task automatic t_sleep_wake;
        int n;
        send_ok(0, nvt_pkg::NVT_CMD_SLEEP);
        wait_bit(B_SLP, 1'b1, nvt_pkg::SEQ_CYC + SLC + 10, n);
        check(access_en === 1'b0, "access open while asleep");
        wake_req = 1'b1;
        tick(1);
        wake_req = 1'b0;
        wait_bit(B_ACC, 1'b1, WC + 10, n);
        check(sleep === 1'b0, "still asleep after wake");
    endtask : t_sleep_wake

    task automatic t_standby;
        int n;
        send_ok(2, nvt_pkg::NVT_CMD_SAVE);
        wait_bit(B_STB, 1'b1, nvt_pkg::STANDBY_CYC + 5, n);
    endtask : t_standby

    task automatic t_power_loss;
        int n;
        send_ok(1, nvt_pkg::NVT_CMD_SAVE);
        auto_save = 1'b1;
        low_trip  = 1'b1;
        wait_bit(B_SGO, 1'b1, 10, n);
        check(access_en === 1'b0, "access open at low supply");
        // Supply stays low past the save before it comes back
        tick(SC + 10);
        check(access_en === 1'b0, "access open at low supply");
        low_trip  = 1'b0;
        auto_save = 1'b0;
        wait_bit(B_ACC, 1'b1, RC + 20, n);
        check(n >= RC - 5, "restore ended too early");
    endtask : t_power_loss

    initial
    begin
        clk        = 1'b0;
        nrst       = 1'b0;
        low_trip   = 1'b0;
        pin_low    = 1'b0;
        auto_save  = 1'b0;
        wake_req   = 1'b0;
        mismatches = 0;
        n_compared = 0;
        tick(10);
        nrst = 1'b1;
        t_restore();
        // A save ends through the pin settle time before access returns
        t_sw_op(nvt_pkg::NVT_CMD_SAVE, B_SGO, SC + nvt_pkg::ACTIVE_CYC);
        t_hw_clean();
        t_sw_op(nvt_pkg::NVT_CMD_RECALL, B_RGO, nvt_pkg::RECALL_CYC);
        t_hw_dirty();
        t_sleep_wake();
        t_standby();
        t_power_loss();
        // Mid-run reset must restart the power-up restore
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        t_restore();
        complete_run();
    end
endmodule : nvt_ctrl_tb
